/* edge_ctl_pkg.sv */
// constants for the charge time unit edge control block
// assumes an apb slave with 32-bit data on a single clock
package edge_ctl_pkg;
	localparam logic [11:0] edge_select_control_addr = 12'h000;
	localparam logic [11:0] discharge_ctl_addr = 12'h004;
	localparam logic [11:0] event_status_addr = 12'h008;
	localparam logic [11:0] event_mask_addr = 12'h00c;
	localparam int first_mod_bit = 15;
	localparam int first_pol_bit = 14;
	localparam int first_sel_hi = 13;
	localparam int first_sel_lo = 10;
	localparam int second_flag_bit = 9;
	localparam int first_flag_bit = 8;
	localparam int second_mod_bit = 7;
	localparam int second_pol_bit = 6;
	localparam int second_sel_hi = 5;
	localparam int second_sel_lo = 2;
	localparam logic [15:0] edge_select_control_reset = 16'h0000;
	localparam logic [15:0] edge_select_control_wmask = 16'hfffc;
	localparam int discharge_bit = 0;
	localparam int first_event_bit = 0;
	localparam int second_event_bit = 1;
	localparam logic [3:0] src_pin_a = 4'h3;
	localparam logic [3:0] src_pin_b = 4'h2;
	localparam logic [3:0] src_compare = 4'h1;
	typedef enum logic [1:0] {
		det_idle = 2'b00,
		det_armed = 2'b01,
		det_hit = 2'b10
	} det_state_t;
endpackage

/* edge_detector.sv */
// one edge channel: source select, polarity, edge or level sampling
// assumes source inputs already synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module edge_detector
	import edge_ctl_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [3:0] source_sel,
	input wire logic polarity,
	input wire logic edge_mode,
	input wire logic pin_a,
	input wire logic pin_b,
	input wire logic compare_src,
	output logic event_hit
);
	logic src;
	logic src_q;
	logic active;
	logic src_valid;
	always_comb begin
		unique case (source_sel)
			src_pin_a: src = pin_a;
			src_pin_b: src = pin_b;
			src_compare: src = compare_src;
			// reserved codes select no source
			default: src = 1'b0;
		endcase
	end
	// reserved codes must never look active, even at negative polarity
	assign src_valid = (source_sel == src_pin_a) | (source_sel == src_pin_b) |
		(source_sel == src_compare);
	assign active = src_valid & (polarity ? src : ~src);
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			src_q <= 1'b0;
		end else begin
			src_q <= active;
		end
	end
	// edge mode needs an inactive to active change, level mode the level alone
	assign event_hit = edge_mode ? (active & ~src_q) : active;
endmodule
`default_nettype wire

/* charge_time_edge_control.sv */
// apb register block and edge logic of the charge time unit
// assumes apb master on ref_clk, edge sources synchronous to ref_clk
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module charge_time_edge_control
	import edge_ctl_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic edge_input_pin_a,
	input wire logic edge_input_pin_b,
	input wire logic output_compare_one,
	input wire logic second_src_0,
	input wire logic adc_sampling,
	output logic discharge_sink_on,
	output logic first_edge_state,
	output logic second_edge_state,
	output logic irq
);
	logic [15:0] edge_select_control;
	logic discharge_sink_enable;
	logic [1:0] event_status;
	logic [1:0] event_mask;
	logic first_hit;
	logic second_hit;
	logic wr;
	logic rd;
	logic first_set;
	logic second_set;

	function automatic logic hit_addr(input logic [11:0] a, input logic [11:0] r);
		return a == r;
	endfunction

	assign wr = psel & penable & pwrite;
	assign rd = psel & penable & ~pwrite;
	assign pready = 1'b1;

	edge_detector first_det (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.source_sel(edge_select_control[first_sel_hi:first_sel_lo]),
		.polarity(edge_select_control[first_pol_bit]),
		.edge_mode(edge_select_control[first_mod_bit]),
		.pin_a(edge_input_pin_a),
		.pin_b(edge_input_pin_b),
		.compare_src(output_compare_one),
		.event_hit(first_hit)
	);

	// second source code 0001 is a separate on-chip source
	edge_detector second_det (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.source_sel(edge_select_control[second_sel_hi:second_sel_lo]),
		.polarity(edge_select_control[second_pol_bit]),
		.edge_mode(edge_select_control[second_mod_bit]),
		.pin_a(edge_input_pin_a),
		.pin_b(edge_input_pin_b),
		.compare_src(second_src_0),
		.event_hit(second_hit)
	);

	assign first_set = first_hit & ~edge_select_control[first_flag_bit];
	assign second_set = second_hit & ~edge_select_control[second_flag_bit];

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			edge_select_control <= edge_select_control_reset;
		end else begin
			if (wr && hit_addr(paddr, edge_select_control_addr)) begin
				edge_select_control <= pwdata[15:0] & edge_select_control_wmask;
			end
			// hardware set wins over a software clear in the same cycle
			if (first_hit) begin
				edge_select_control[first_flag_bit] <= 1'b1;
			end
			if (second_hit) begin
				edge_select_control[second_flag_bit] <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			discharge_sink_enable <= 1'b0;
		end else if (wr && hit_addr(paddr, discharge_ctl_addr)) begin
			discharge_sink_enable <= pwdata[discharge_bit];
		end
	end

	// no automatic discharge path exists; the software bit drives it, gated by adc_sampling
	assign discharge_sink_on = discharge_sink_enable & adc_sampling;
	assign first_edge_state = edge_select_control[first_flag_bit];
	assign second_edge_state = edge_select_control[second_flag_bit];

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			event_status <= 2'b00;
		end else begin
			if (rd && hit_addr(paddr, event_status_addr)) begin
				event_status <= 2'b00;
			end
			if (first_set) begin
				event_status[first_event_bit] <= 1'b1;
			end
			if (second_set) begin
				event_status[second_event_bit] <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			event_mask <= 2'b00;
		end else if (wr && hit_addr(paddr, event_mask_addr)) begin
			event_mask <= pwdata[1:0];
		end
	end

	assign irq = |(event_status & event_mask);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				edge_select_control_addr: prdata <= {16'h0000, edge_select_control};
				discharge_ctl_addr: prdata <= {31'h00000000, discharge_sink_enable};
				event_status_addr: prdata <= {30'h00000000, event_status};
				event_mask_addr: prdata <= {30'h00000000, event_mask};
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	assign pslverr = psel & penable & ~(hit_addr(paddr, edge_select_control_addr) |
		hit_addr(paddr, discharge_ctl_addr) | hit_addr(paddr, event_status_addr) |
		hit_addr(paddr, event_mask_addr));
endmodule
`default_nettype wire

/* edge_ctl_props.sv */
// port assertions for the edge control block
// bound to charge_time_edge_control, one clock domain
`timescale 1ns/1ps
`default_nettype none
module edge_ctl_props
	import edge_ctl_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic adc_sampling,
	input wire logic discharge_sink_on,
	input wire logic first_edge_state,
	input wire logic second_edge_state
);
	wire acc = psel && penable;
	wire hit = paddr[11:4] == 8'h00 && paddr[1:0] == 2'h0;
	wire wr0 = acc && pwrite && paddr == edge_select_control_addr;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	a_ready_high: assert property (pready)
		else $error("pready low");
	a_err_unmapped: assert property (acc && !hit |-> pslverr)
		else $error("no error");
	a_err_mapped: assert property (acc && hit |-> !pslverr)
		else $error("bad error");
	a_first_write: assert property (wr0 && pwdata[first_flag_bit] |=> first_edge_state)
		else $error("flag1 write");
	a_second_write: assert property (wr0 && pwdata[second_flag_bit] |=> second_edge_state)
		else $error("flag2 write");
	a_first_hold: assert property (first_edge_state && !wr0 |=> first_edge_state)
		else $error("flag1 lost");
	a_second_hold: assert property (second_edge_state && !wr0 |=> second_edge_state)
		else $error("flag2 lost");
	a_sink_gate: assert property (!adc_sampling |-> !discharge_sink_on)
		else $error("sink open");
	cover property (discharge_sink_on);
	cover property (acc && pslverr);
	cover property (second_edge_state);
endmodule
bind charge_time_edge_control edge_ctl_props edge_ctl_props_i (.*);
`default_nettype wire

/* edge_src.sv */
// edge sources and adc sampling level
// levels follow the bench command one clock later
`timescale 1ns/1ps
`default_nettype none
module edge_src (
	input wire logic ref_clk,
	input wire logic [4:0] cmd,
	output logic [4:0] lvl
);
	initial lvl = 5'h00;
	// sampling stays up as long as the bench holds cmd bit 4 high
	always @(posedge ref_clk) lvl <= cmd;
endmodule
`default_nettype wire

/* tb.sv */
// self-checking bench for the edge control block
// uses edge_src and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb;
	import edge_ctl_pkg::*;
	localparam logic [11:0] ctl = edge_select_control_addr;
	logic ref_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, e, d;
	logic pready, pslverr, discharge_sink_on, s2, irq;
	logic [4:0] cmd = 5'h00, lv;
	logic [31:0] exp_q[$];
	int mismatches = 0;
	int n_checks = 0;
	always #4 ref_clk = ~ref_clk;
	edge_src edge_src_i (.ref_clk(ref_clk), .cmd(cmd), .lvl(lv));
	charge_time_edge_control charge_time_edge_control_i (.*, .edge_input_pin_a(lv[0]),
		.edge_input_pin_b(lv[1]), .output_compare_one(lv[2]), .second_src_0(lv[3]),
		.adc_sampling(lv[4]), .first_edge_state(), .second_edge_state(s2));
	task chk(input logic [31:0] s, input logic [31:0] x);
		n_checks++;
		if (s !== x) begin
			mismatches++;
			$display("BAD %0t %h %h", $time, s, x);
		end
	endtask
	task bus(input logic w, input logic [11:0] a, input logic [31:0] v);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] x);
		exp_q.push_back(x);
		bus(1'b0, a, 32'h0);
	endtask
	task summarize;
		if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		if (psel && penable && pready && !pwrite)
			chk(prdata, exp_q.pop_front());
	end
	initial begin
		d = $urandom(32'h31267c35) & 32'h3;
		repeat (4) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		rd(ctl, 32'h0);
		bus(1'b1, ctl, 32'hffff);
		chk(s2, 1'b1);
		rd(ctl, 32'hfffc);
		for (int i = 1; i < 5; i++) begin
			bus(1'b1, ctl, 32'h4000);
			cmd <= (i < 4) ? 5'(1 << (3 - i)) : 5'h07;
			e = 32'h4000 | (i << 10);
			bus(1'b1, ctl, e);
			cmd <= 5'h00;
			rd(ctl, e | (i < 4 ? 32'h100 : 32'h0));
		end
		bus(1'b1, event_mask_addr, d);
		rd(event_mask_addr, d);
		bus(1'b1, event_mask_addr, 32'h1);
		chk(irq, 1'b1);
		rd(event_status_addr, 32'h1);
		chk(irq, 1'b0);
		bus(1'b1, ctl, 32'h00c4);
		cmd <= 5'h08;
		repeat (4) @(posedge ref_clk);
		rd(ctl, 32'h02c4);
		bus(1'b1, ctl, 32'h00c4);
		rd(ctl, 32'h00c4);
		cmd <= 5'h10;
		bus(1'b1, discharge_ctl_addr, 32'h0);
		chk(discharge_sink_on, 1'b0);
		bus(1'b1, discharge_ctl_addr, 32'h1);
		chk(discharge_sink_on, 1'b1);
		cmd <= 5'h00;
		repeat (2) @(posedge ref_clk);
		chk(discharge_sink_on, 1'b0);
		rd(12'h010, 32'h0);
		summarize();
	end
	initial begin
		#100000;
		mismatches++;
		summarize();
	end
endmodule
`default_nettype wire
